// ---- design/wts_defines.vh ----
/*
  constants for the wakeup timer / undervolt system control block:
  register byte offsets, field positions, reset values, timing counts.
  assumes a 100 mhz core clock and 32-bit axi4-lite access.
*/
`ifndef WTS_DEFINES_VH
`define WTS_DEFINES_VH

// register byte offsets
`define WTS_OFF_ID_HIGH      8'h00
`define WTS_OFF_ID_LOW       8'h04
`define WTS_OFF_WAKE_CTRL    8'h08
`define WTS_OFF_PWR_CTRL     8'h0c
`define WTS_OFF_IRQ_STATUS   8'h10
`define WTS_OFF_IRQ_ENABLE   8'h14
`define WTS_OFF_IRQ_CLEAR    8'h18
`define WTS_OFF_ENV          8'h1c

// wakeup control fields
`define WTS_WK_FLAG_BIT      7
`define WTS_WK_ACK_BIT       6
`define WTS_WK_CLKSEL_BIT    5
`define WTS_WK_IE_BIT        4

// power control fields
`define WTS_PW_FLAG_BIT      7
`define WTS_PW_ACK_BIT       6
`define WTS_PW_IE_BIT        5
`define WTS_PW_RE_BIT        4
`define WTS_PW_SE_BIT        3
`define WTS_PW_DE_BIT        2
`define WTS_PW_BG_BIT        1

// reset values
`define WTS_WAKE_RST         8'h00
`define WTS_PWR_RST          8'h1c

// internal oscillator: 1 khz tick, period in ns
`define WTS_OSC_PERIOD_NS    1000000
`define WTS_CLK_PERIOD_NS    10
`define WTS_OSC_TICK_CYC     (`WTS_OSC_PERIOD_NS / `WTS_CLK_PERIOD_NS)

// axi responses
`define WTS_RESP_OKAY        2'b00
`define WTS_RESP_SLVERR      2'b10

`endif

// ---- design/wts_sysctrl.v ----
/*
  wakeup timer and undervolt detect control registers behind an axi4-lite
  slave, with sticky interrupt status, enable and clear registers.
  assumes: undervolt_event, stop_mode and ext_clk_tick are synchronous
  to core_clk; ext_clk_tick is a one-cycle pulse per external clock edge.
*/
`timescale 1ns/1ps
`include "wts_defines.vh"

module wts_sysctrl #(
  parameter [11:0] PART_NUMBER = 12'h5a3,              // arbitrary value
  parameter [3:0]  RSVD_VALUE  = 4'h0,                 // reserved id bits
  parameter        OSC_TICK    = `WTS_OSC_TICK_CYC     // cycles per 1 ms
) (
  input  wire        core_clk,
  input  wire        sys_rst,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        ext_clk_tick,
  input  wire        undervolt_event,
  input  wire        stop_mode,
  output reg         wakeup_irq_q,
  output reg         undervolt_irq_q,
  output reg         undervolt_reset_q,
  output reg         bandgap_buffer_en_q,
  output reg         undervolt_detect_on_q,
  output reg         irq_q
);

  // one-hot states of the write channel
  localparam [2:0] WS_IDLE = 3'b001;
  localparam [2:0] WS_RESP = 3'b010;
  localparam [2:0] WS_HOLD = 3'b100;

  // control fields
  reg        wakeup_timeout_flag_q;                    // sticky timeout
  reg        wakeup_clock_select_q;                    // 0 internal, 1 ext
  reg        wakeup_irq_enable_q;
  reg [2:0]  wakeup_delay_select_q;
  reg        undervolt_flag_q;
  reg        undervolt_irq_enable_q;
  reg        undervolt_reset_enable_q;
  reg        undervolt_stop_enable_q;
  reg        undervolt_detect_enable_q;
  reg        bandgap_buffer_enable_q;
  // interrupt aggregation registers
  reg [1:0]  irq_status_q;                             // sticky events
  reg [1:0]  irq_enable_q;
  // timer state
  reg [16:0] osc_cnt_q;                                // 1 ms prescaler
  reg [15:0] wake_cnt_q;                               // ticks so far
  // bus state
  reg [2:0]  wstate_q;
  reg        aw_seen_q;
  reg        w_seen_q;
  reg [7:0]  aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0]  w_strb_q;

  // terminal tick count for a delay code and clock source
  function [15:0] wake_limit;
    input [2:0] sel;
    input       ext;
    begin
      if (ext) begin
        case (sel)
          3'h1:    wake_limit = 16'd256;
          3'h2:    wake_limit = 16'd1024;
          3'h3:    wake_limit = 16'd2048;
          3'h4:    wake_limit = 16'd4096;
          3'h5:    wake_limit = 16'd8192;
          3'h6:    wake_limit = 16'd16384;
          3'h7:    wake_limit = 16'd32768;
          default: wake_limit = 16'd0;
        endcase
      end else begin
        case (sel)
          3'h1:    wake_limit = 16'd8;
          3'h2:    wake_limit = 16'd32;
          3'h3:    wake_limit = 16'd64;
          3'h4:    wake_limit = 16'd128;
          3'h5:    wake_limit = 16'd256;
          3'h6:    wake_limit = 16'd512;
          3'h7:    wake_limit = 16'd1024;
          default: wake_limit = 16'd0;
        endcase
      end
    end
  endfunction

  // register read mux
  function [31:0] read_word;
    input [7:0] a;
    begin
      case (a)
        `WTS_OFF_ID_HIGH:
          read_word = {24'h0, RSVD_VALUE, PART_NUMBER[11:8]};
        `WTS_OFF_ID_LOW:
          read_word = {24'h0, PART_NUMBER[7:0]};
        `WTS_OFF_WAKE_CTRL:
          read_word = {24'h0, wakeup_timeout_flag_q, 1'b0,
                       wakeup_clock_select_q, wakeup_irq_enable_q,
                       1'b0, wakeup_delay_select_q};
        `WTS_OFF_PWR_CTRL:
          read_word = {24'h0, undervolt_flag_q, 1'b0,
                       undervolt_irq_enable_q, undervolt_reset_enable_q,
                       undervolt_stop_enable_q, undervolt_detect_enable_q,
                       bandgap_buffer_enable_q, 1'b0};
        `WTS_OFF_IRQ_STATUS: read_word = {30'h0, irq_status_q};
        `WTS_OFF_IRQ_ENABLE: read_word = {30'h0, irq_enable_q};
        default:             read_word = 32'h0;
      endcase
    end
  endfunction

  // decode of a complete write
  wire        wr_go    = (wstate_q == WS_IDLE) && aw_seen_q && w_seen_q;
  wire        wr_lane0 = wr_go && w_strb_q[0];
  wire        wr_wake  = wr_lane0 && (aw_addr_q == `WTS_OFF_WAKE_CTRL);
  wire        wr_pwr   = wr_lane0 && (aw_addr_q == `WTS_OFF_PWR_CTRL);
  wire        wr_clr   = wr_lane0 && (aw_addr_q == `WTS_OFF_IRQ_CLEAR);
  wire        wr_ien   = wr_lane0 && (aw_addr_q == `WTS_OFF_IRQ_ENABLE);
  wire        wr_ok    = (aw_addr_q <= `WTS_OFF_ENV) && (aw_addr_q[1:0] == 2'b00)
                         && (aw_addr_q != `WTS_OFF_ENV);
  wire [15:0] limit    = wake_limit(wakeup_delay_select_q, wakeup_clock_select_q);
  wire        osc_tick = (osc_cnt_q == OSC_TICK - 1);
  wire        src_tick = wakeup_clock_select_q ? ext_clk_tick : osc_tick;
  wire        timer_on = (wakeup_delay_select_q != 3'h0);
  wire        timeout  = timer_on && src_tick && (wake_cnt_q == limit - 16'd1);
  // detection runs when enabled, and in stop mode only with stop enable
  wire        detect_live = undervolt_detect_enable_q &&
                            (!stop_mode || undervolt_stop_enable_q);
  wire        uv_set   = detect_live && undervolt_event;
  wire        wk_ack   = wr_wake && w_data_q[`WTS_WK_ACK_BIT];
  wire        uv_ack   = wr_pwr && w_data_q[`WTS_PW_ACK_BIT];

  // internal 1 khz tick prescaler
  always @(posedge core_clk) begin
    if (sys_rst || wakeup_clock_select_q) begin
      osc_cnt_q <= 17'h0;
    end else if (osc_tick) begin
      osc_cnt_q <= 17'h0;
    end else begin
      osc_cnt_q <= osc_cnt_q + 17'h1;
    end
  end

  // wakeup tick counter, restarts after each timeout
  always @(posedge core_clk) begin
    if (sys_rst || !timer_on || wr_wake) begin
      wake_cnt_q <= 16'h0;
    end else if (timeout) begin
      wake_cnt_q <= 16'h0;
    end else if (src_tick) begin
      wake_cnt_q <= wake_cnt_q + 16'h1;
    end
  end

  // control register fields and flags; a set beats a same-cycle ack
  always @(posedge core_clk) begin
    if (sys_rst) begin
      wakeup_timeout_flag_q     <= 1'b0;
      wakeup_clock_select_q     <= 1'b0;
      wakeup_irq_enable_q       <= 1'b0;
      wakeup_delay_select_q     <= 3'h0;
      undervolt_flag_q          <= 1'b0;
      undervolt_irq_enable_q    <= 1'b0;
      undervolt_reset_enable_q  <= 1'b1;
      undervolt_stop_enable_q   <= 1'b1;
      undervolt_detect_enable_q <= 1'b1;
      bandgap_buffer_enable_q   <= 1'b0;
    end else begin
      if (timeout) begin
        wakeup_timeout_flag_q <= 1'b1;
      end else if (wk_ack) begin
        wakeup_timeout_flag_q <= 1'b0;
      end
      if (uv_set) begin
        undervolt_flag_q <= 1'b1;
      end else if (uv_ack) begin
        undervolt_flag_q <= 1'b0;
      end
      if (wr_wake) begin
        wakeup_clock_select_q <= w_data_q[`WTS_WK_CLKSEL_BIT];
        wakeup_irq_enable_q   <= w_data_q[`WTS_WK_IE_BIT];
        wakeup_delay_select_q <= w_data_q[2:0];
      end
      if (wr_pwr) begin
        undervolt_irq_enable_q    <= w_data_q[`WTS_PW_IE_BIT];
        undervolt_reset_enable_q  <= w_data_q[`WTS_PW_RE_BIT];
        undervolt_stop_enable_q   <= w_data_q[`WTS_PW_SE_BIT];
        undervolt_detect_enable_q <= w_data_q[`WTS_PW_DE_BIT];
        bandgap_buffer_enable_q   <= w_data_q[`WTS_PW_BG_BIT];
      end
    end
  end

  // sticky event status, enable and write-one-to-clear
  always @(posedge core_clk) begin
    if (sys_rst) begin
      irq_status_q <= 2'b00;
      irq_enable_q <= 2'b00;
    end else begin
      irq_status_q <= (irq_status_q & ~(wr_clr ? w_data_q[1:0] : 2'b00))
                      | {uv_set, timeout};
      if (wr_ien) begin
        irq_enable_q <= w_data_q[1:0];
      end
    end
  end

  // block outputs, all registered
  always @(posedge core_clk) begin
    if (sys_rst) begin
      wakeup_irq_q          <= 1'b0;
      undervolt_irq_q       <= 1'b0;
      undervolt_reset_q     <= 1'b0;
      bandgap_buffer_en_q   <= 1'b0;
      undervolt_detect_on_q <= 1'b0;
      irq_q                 <= 1'b0;
    end else begin
      wakeup_irq_q          <= wakeup_timeout_flag_q & wakeup_irq_enable_q;
      undervolt_irq_q       <= undervolt_flag_q & undervolt_irq_enable_q;
      undervolt_reset_q     <= undervolt_flag_q & undervolt_reset_enable_q
                               & undervolt_detect_enable_q;
      bandgap_buffer_en_q   <= bandgap_buffer_enable_q;
      undervolt_detect_on_q <= detect_live;
      irq_q                 <= |(irq_status_q & irq_enable_q);
    end
  end

  // write channel: capture address and data in either order
  always @(posedge core_clk) begin
    if (sys_rst) begin
      wstate_q      <= WS_IDLE;
      aw_seen_q     <= 1'b0;
      w_seen_q      <= 1'b0;
      aw_addr_q     <= 8'h0;
      w_data_q      <= 32'h0;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `WTS_RESP_OKAY;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      case (wstate_q)
        WS_IDLE: begin
          if (s_axi_awvalid && !aw_seen_q && !s_axi_awready) begin
            s_axi_awready <= 1'b1;
            aw_addr_q     <= s_axi_awaddr;
          end
          if (s_axi_awready) begin
            aw_seen_q <= 1'b1;
          end
          if (s_axi_wvalid && !w_seen_q && !s_axi_wready) begin
            s_axi_wready <= 1'b1;
            w_data_q     <= s_axi_wdata;
            w_strb_q     <= s_axi_wstrb;
          end
          if (s_axi_wready) begin
            w_seen_q <= 1'b1;
          end
          if (aw_seen_q && w_seen_q) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `WTS_RESP_OKAY : `WTS_RESP_SLVERR;
            wstate_q     <= WS_RESP;
          end
        end
        WS_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_seen_q    <= 1'b0;
            w_seen_q     <= 1'b0;
            wstate_q     <= WS_HOLD;
          end
        end
        WS_HOLD: begin
          wstate_q <= WS_IDLE;
        end
        default: begin
          wstate_q <= WS_IDLE;
        end
      endcase
    end
  end

  // read channel: one read at a time, data from the mux
  always @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `WTS_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else if (s_axi_arvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= read_word(s_axi_araddr);
        s_axi_rresp   <= ((s_axi_araddr < `WTS_OFF_ENV) && (s_axi_araddr[1:0] == 2'b00))
                         ? `WTS_RESP_OKAY : `WTS_RESP_SLVERR;
      end
    end
  end

endmodule // wts_sysctrl

// ---- sim/wts_sysctrl_asserts.sv ----
/*
  port checker for the wakeup timer / undervolt control block.
  assumes one clock, core_clk, and a synchronous active-high sys_rst.
*/
`timescale 1ns/1ps
module wts_sysctrl_asserts (
  input logic        core_clk,
  input logic        sys_rst,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic [1:0]  s_axi_bresp,
  input logic [7:0]  s_axi_araddr,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic        stop_mode,
  input logic        wakeup_irq_q,
  input logic        undervolt_irq_q,
  input logic        undervolt_reset_q,
  input logic        undervolt_detect_on_q,
  input logic        irq_q
);
  // single domain, reset masks every check
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // read answer one cycle after request
  a_rd_answer: assert property ($rose(s_axi_arvalid) |=> s_axi_rvalid)
    else $error("read answer missing");
  // read data stands until taken
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  // write response stands until taken
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  // write response follows both handshakes
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write answer missing");
  // address ready is a single pulse
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held too long");
  // unmapped read refused with zero data
  a_rd_unmapped: assert property (s_axi_arready && s_axi_araddr >= 8'h1c
    |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  // only the low byte carries data
  a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  // reset request needs live detection outside stop mode
  a_uv_gate: assert property (undervolt_reset_q && !stop_mode |-> undervolt_detect_on_q)
    else $error("reset request without detection");
  // requests quiet right after reset
  a_reset_quiet: assert property ($fell(sys_rst) |-> !irq_q && !wakeup_irq_q
    && !undervolt_irq_q && !undervolt_reset_q) else $error("request high after reset");
  // detection live soon after reset
  a_detect_up: assert property ($fell(sys_rst) && !stop_mode |-> ##[1:2] undervolt_detect_on_q)
    else $error("detection not live after reset");
endmodule // wts_sysctrl_asserts

bind wts_sysctrl wts_sysctrl_asserts chk (
  .core_clk              (core_clk),
  .sys_rst               (sys_rst),
  .s_axi_awvalid         (s_axi_awvalid),
  .s_axi_awready         (s_axi_awready),
  .s_axi_wvalid          (s_axi_wvalid),
  .s_axi_wready          (s_axi_wready),
  .s_axi_bvalid          (s_axi_bvalid),
  .s_axi_bready          (s_axi_bready),
  .s_axi_bresp           (s_axi_bresp),
  .s_axi_araddr          (s_axi_araddr),
  .s_axi_arvalid         (s_axi_arvalid),
  .s_axi_arready         (s_axi_arready),
  .s_axi_rdata           (s_axi_rdata),
  .s_axi_rresp           (s_axi_rresp),
  .s_axi_rvalid          (s_axi_rvalid),
  .s_axi_rready          (s_axi_rready),
  .stop_mode             (stop_mode),
  .wakeup_irq_q          (wakeup_irq_q),
  .undervolt_irq_q       (undervolt_irq_q),
  .undervolt_reset_q     (undervolt_reset_q),
  .undervolt_detect_on_q (undervolt_detect_on_q),
  .irq_q                 (irq_q)
);

// ---- sim/wts_sysctrl_bench.sv ----
/*
  self-checking bench for the wakeup timer / undervolt control block.
  assumes the slave registers all outputs; OSC_TICK shortened to 4.
*/
`timescale 1ns/1ps
module wts_sysctrl_bench;
  logic core_clk = '0, sys_rst = '1, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0, ext_clk_tick = '0, undervolt_event = '0;
  logic stop_mode = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic wakeup_irq_q, undervolt_irq_q, undervolt_reset_q, bandgap_buffer_en_q;
  logic undervolt_detect_on_q, irq_q;
  logic [7:0]  mdl [8] = '{8'h05, 8'ha3, 8'h00, 8'h1c, 8'h00, 8'h00, 8'h00, 8'h00}; // expected regs
  int unsigned rs = 75; // xorshift state
  int bad_count = 0, checked = 0;

  wts_sysctrl #(.PART_NUMBER(12'h5a3), .RSVD_VALUE(4'h0), .OSC_TICK(4)) dut (
    .core_clk              (core_clk),
    .sys_rst               (sys_rst),
    .s_axi_awaddr          (s_axi_awaddr),
    .s_axi_awvalid         (s_axi_awvalid),
    .s_axi_awready         (s_axi_awready),
    .s_axi_wdata           (s_axi_wdata),
    .s_axi_wstrb           (s_axi_wstrb),
    .s_axi_wvalid          (s_axi_wvalid),
    .s_axi_wready          (s_axi_wready),
    .s_axi_bresp           (s_axi_bresp),
    .s_axi_bvalid          (s_axi_bvalid),
    .s_axi_bready          (s_axi_bready),
    .s_axi_araddr          (s_axi_araddr),
    .s_axi_arvalid         (s_axi_arvalid),
    .s_axi_arready         (s_axi_arready),
    .s_axi_rdata           (s_axi_rdata),
    .s_axi_rresp           (s_axi_rresp),
    .s_axi_rvalid          (s_axi_rvalid),
    .s_axi_rready          (s_axi_rready),
    .ext_clk_tick          (ext_clk_tick),
    .undervolt_event       (undervolt_event),
    .stop_mode             (stop_mode),
    .wakeup_irq_q          (wakeup_irq_q),
    .undervolt_irq_q       (undervolt_irq_q),
    .undervolt_reset_q     (undervolt_reset_q),
    .bandgap_buffer_en_q   (bandgap_buffer_en_q),
    .undervolt_detect_on_q (undervolt_detect_on_q),
    .irq_q                 (irq_q)
  );

  // 100 mhz clock
  always #5 core_clk = ~core_clk;
  // random external timer ticks
  always @(posedge core_clk) ext_clk_tick <= 1'(xs());

  function automatic int unsigned xs();
    rs ^= rs << 13; rs ^= rs >> 17; rs ^= rs << 5;
    return rs;
  endfunction

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // model update on a write
  function automatic void mdl_wr(logic [7:0] a, logic [7:0] d);
    case (a)
      8'h08: mdl[2] = (d[6] ? 8'h00 : mdl[2] & 8'h80) | (d & 8'h37);
      8'h0c: mdl[3] = (d[6] ? 8'h00 : mdl[3] & 8'h80) | (d & 8'h3e);
      8'h14: mdl[5] = d & 8'h03;
      8'h18: mdl[4] = mdl[4] & ~d;
      default: ;
    endcase
  endfunction

  // axi write, bready raised once response seen
  task automatic wr(logic [7:0] a, logic [7:0] d);
    bit ga, gw;
    ga = 0; gw = 0;
    s_axi_awaddr <= a; s_axi_wdata <= {24'(xs()), d};
    s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    while (!(ga && gw)) begin
      @(posedge core_clk);
      if (s_axi_awready) begin ga = 1; s_axi_awvalid <= 0; end
      if (s_axi_wready) begin gw = 1; s_axi_wvalid <= 0; end
    end
    while (!s_axi_bvalid) @(posedge core_clk);
    s_axi_bready <= 1;
    @(posedge core_clk);
    s_axi_bready <= 0;
    chk("bresp", s_axi_bresp, a < 8'h1c ? 2'h0 : 2'h2);
    mdl_wr(a, d);
    @(posedge core_clk);
  endtask

  // axi read compared with the model
  task automatic rd(logic [7:0] a);
    s_axi_araddr <= a; s_axi_arvalid <= 1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 0; s_axi_rready <= 1;
    do @(posedge core_clk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
    chk("rdata", s_axi_rdata, a < 8'h1c ? mdl[a[4:2]] : 8'h00);
    chk("rresp", s_axi_rresp, a < 8'h1c ? 2'h0 : 2'h2);
    @(posedge core_clk);
  endtask

  // run one timeout, then acknowledge it
  task automatic tmo(logic [2:0] c, bit e);
    int n, x;
    x = e ? (c == 1 ? 256 : 256 << c) : (c == 1 ? 8 : 16 << (c - 1)) * 4;
    wr(8'h08, {2'h0, e, 2'h2, c});
    n = 0;
    while (!wakeup_irq_q && n < x + 50) begin
      @(posedge core_clk);
      n += e ? int'(ext_clk_tick) : 1;
    end
    chk("timeout", n >= x - 8 && n <= x + 8, 1);
    mdl[2] |= 8'h80; mdl[4] |= 8'h01;
    rd(8'h08);
    wr(8'h08, {2'h1, e, 2'h2, c});
    rd(8'h08);
  endtask

  // one undervolt event pulse
  task automatic uv(bit set);
    undervolt_event <= 1;
    @(posedge core_clk);
    undervolt_event <= 0;
    repeat (3) @(posedge core_clk);
    if (set) begin mdl[3] |= 8'h80; mdl[4] |= 8'h02; end
    rd(8'h0c);
  endtask

  task automatic tally_and_finish();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // watchdog at about two and a half times the expected run of some 12k cycles
  initial begin
    #300000;
    bad_count++;
    tally_and_finish();
  end

  // main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 0;
    @(posedge core_clk);
    chk("irq", {irq_q, wakeup_irq_q, undervolt_irq_q, bandgap_buffer_en_q}, 0);
    for (int i = 0; i < 8; i++) rd(8'(i * 4));
    chk("det_on", undervolt_detect_on_q, 1);
    wr(8'h00, 8'hff); wr(8'h1c, 8'hff); rd(8'h00);
    for (int c = 1; c < 8; c++) tmo(3'(c), 0);
    tmo(3'h1, 1); tmo(3'h2, 1);
    wr(8'h08, 8'h10); repeat (300) @(posedge core_clk); rd(8'h08);
    wr(8'h08, 8'h01); repeat (60) @(posedge core_clk);
    chk("wk_irq", wakeup_irq_q, 0);
    mdl[2] |= 8'h80; mdl[4] |= 8'h01; rd(8'h08);
    wr(8'h08, 8'h40); rd(8'h08);
    wr(8'h0c, 8'h3e); chk("bg", bandgap_buffer_en_q, 1);
    uv(1); chk("uv_req", {undervolt_irq_q, undervolt_reset_q}, 2'h3);
    wr(8'h0c, 8'h7c); rd(8'h0c); chk("uv_irq", undervolt_irq_q, 0);
    chk("bg", bandgap_buffer_en_q, 0);
    stop_mode <= 1; wr(8'h0c, 8'h34); chk("det_on", undervolt_detect_on_q, 0); uv(0);
    wr(8'h0c, 8'h3c); chk("det_on", undervolt_detect_on_q, 1); stop_mode <= 0;
    wr(8'h0c, 8'h20); uv(0); chk("uv_rst", undervolt_reset_q, 0);
    wr(8'h0c, 8'h2c); uv(1); chk("uv_req", {undervolt_irq_q, undervolt_reset_q}, 2'h2);
    wr(8'h0c, 8'h6c); wr(8'h18, 8'h03); rd(8'h10); rd(8'h18);
    wr(8'h14, 8'h01); rd(8'h14); uv(1); rd(8'h10);
    chk("irq", irq_q, 0);
    wr(8'h14, 8'h03); chk("irq", irq_q, 1);
    wr(8'h18, 8'h02); rd(8'h10); chk("irq", irq_q, 0);
    tally_and_finish();
  end
endmodule // wts_sysctrl_bench
